//--- mcg_clk_div.sv
// free-running tick divider with restart, level and end-of-period pulse
`timescale 1ns/10ps
`default_nettype none
module mcg_clk_div (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // control
  input  wire logic       tick,
  input  wire logic       restart,
  input  wire logic [6:0] period,
  // divided clock
  output logic            level,
  output logic            wrap
);

  logic [6:0] cnt_q;
  logic [6:0] cnt_d;

  // high for the first half of the period, low for the rest
  assign level = (cnt_q < {1'b0, period[6:1]});
  assign wrap  = tick && (cnt_q >= period - 7'h01);

  // next count
  always_comb begin
    cnt_d = cnt_q;
    if (restart) begin
      cnt_d = 7'h00;
    end else if (wrap) begin
      cnt_d = 7'h00;
    end else if (tick) begin
      cnt_d = cnt_q + 7'h01;
    end
  end

  // count register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : mcg_clk_div
`default_nettype wire

//--- mcg_clock_output.sv
// microcontroller clock output generator with sleep switch and clock tail
`timescale 1ns/10ps
`default_nettype none
module mcg_clock_output (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  // oscillator ticks and chip mode
  input  wire logic       xtalTick,
  input  wire logic       lfTick,
  input  wire logic       sleepCmd,
  input  wire logic       irqPending,
  // outputs
  output logic            clockOutPinO,
  output logic            clockOutPinOe,
  output logic            xtalEnable
);

  // divider period for a select code
  function automatic logic [6:0] sel_period(input logic [2:0] sel);
    case (sel)
      mcg_pkg::SEL_30MHZ: sel_period = mcg_pkg::PER_30MHZ;
      mcg_pkg::SEL_15MHZ: sel_period = mcg_pkg::PER_15MHZ;
      mcg_pkg::SEL_10MHZ: sel_period = mcg_pkg::PER_10MHZ;
      mcg_pkg::SEL_4MHZ:  sel_period = mcg_pkg::PER_4MHZ;
      mcg_pkg::SEL_3MHZ:  sel_period = mcg_pkg::PER_3MHZ;
      mcg_pkg::SEL_2MHZ:  sel_period = mcg_pkg::PER_2MHZ;
      default:            sel_period = mcg_pkg::PER_1MHZ;
    endcase
  endfunction : sel_period

  // tail length for a tail code
  function automatic logic [9:0] tail_len(input logic [1:0] code);
    case (code)
      2'h1:    tail_len = mcg_pkg::TAIL_128;
      2'h2:    tail_len = mcg_pkg::TAIL_256;
      2'h3:    tail_len = mcg_pkg::TAIL_512;
      default: tail_len = mcg_pkg::TAIL_NONE;
    endcase
  endfunction : tail_len

  logic [7:0]          ctrl_q;
  logic [7:0]          ctrl_d;
  logic [7:0]          rdData_q;
  logic [7:0]          rdData_d;
  mcg_pkg::mcg_state_t state_q;
  mcg_pkg::mcg_state_t state_d;
  logic [9:0]          tail_q;
  logic [9:0]          tail_d;
  logic                lfLevel_q;
  logic                lfLevel_d;
  logic                pin_q;
  logic                pin_d;
  logic                pinOe_q;
  logic                xtalEn_q;
  logic                xtalEn_d;
  logic                divRestart;
  logic                divLevel;
  logic                divWrap;
  logic [2:0]          sel;
  logic                lfEn;
  logic [1:0]          tailCode;
  logic                sleepEff;
  logic                useLf;
  logic                curLevel;
  logic                curWrap;
  logic [7:0]          status;

  // control fields
  assign sel      = ctrl_q[mcg_pkg::SEL_LSB +: 3];
  assign lfEn     = ctrl_q[mcg_pkg::LFEN_BIT];
  assign tailCode = ctrl_q[mcg_pkg::TAIL_LSB +: 2];

  // sleep only takes effect once no interrupt is pending
  assign sleepEff = sleepCmd && !irqPending;

  // source select: low-frequency in ST_LOWF (lf sleep) or for code 111
  assign useLf    = (state_q == mcg_pkg::ST_LOWF) || (sel == mcg_pkg::SEL_LF);
  assign curLevel = useLf ? lfLevel_q : divLevel;
  assign curWrap  = useLf ? (lfTick && lfLevel_q) : divWrap; // lf period ends on its falling edge, divider period on its rising edge

  // crystal divider
  mcg_clk_div u_div (
    .mclk    (mclk),
    .reset   (reset),
    .tick    (xtalTick),
    .restart (divRestart),
    .period  (sel_period(sel)),
    .level   (divLevel),
    .wrap    (divWrap)
  );

  // low-frequency clock toggles on each half-period tick
  assign lfLevel_d = lfTick ? !lfLevel_q : lfLevel_q;

  // output state machine
  always_comb begin
    state_d    = state_q;
    tail_d     = tail_q;
    divRestart = 1'b0;
    case (state_q)
      mcg_pkg::ST_RUN: begin
        if (sleepEff && curWrap) begin
          if (lfEn) begin
            state_d = mcg_pkg::ST_LOWF;
          end else if (tail_len(tailCode) == mcg_pkg::TAIL_NONE) begin
            state_d = mcg_pkg::ST_STOPPED;
          end else begin
            state_d = mcg_pkg::ST_TAIL;
            tail_d  = tail_len(tailCode);
          end
        end
      end
      mcg_pkg::ST_TAIL: begin
        if (!sleepEff) begin
          state_d = mcg_pkg::ST_RUN;
        end else if (curWrap) begin
          tail_d = tail_q - 10'h001;
          if (tail_q == 10'h001) begin
            state_d = mcg_pkg::ST_STOPPED;
          end
        end
      end
      mcg_pkg::ST_STOPPED: begin
        if (!sleepEff) begin
          state_d    = mcg_pkg::ST_RUN;
          divRestart = 1'b1;
        end
      end
      mcg_pkg::ST_LOWF: begin
        if (!sleepEff && curWrap) begin
          state_d    = mcg_pkg::ST_RUN;
          divRestart = 1'b1;
        end
      end
      default: begin
        state_d = mcg_pkg::ST_RUN;
      end
    endcase
  end

  // pin level, low while stopped
  always_comb begin
    pin_d = curLevel;
    if (state_q == mcg_pkg::ST_STOPPED) begin
      pin_d = 1'b0;
    end
  end

  // crystal runs except in sleep once the output no longer needs it
  always_comb begin
    xtalEn_d = 1'b1;
    if (sleepEff && (state_q == mcg_pkg::ST_STOPPED || state_q == mcg_pkg::ST_LOWF)) begin
      xtalEn_d = 1'b0;
    end
  end

  // status word
  always_comb begin
    status = 8'h00;
    status[mcg_pkg::STAT_RUN_BIT]  = (state_q != mcg_pkg::ST_STOPPED);
    status[mcg_pkg::STAT_LF_BIT]   = useLf;
    status[mcg_pkg::STAT_TAIL_BIT] = (state_q == mcg_pkg::ST_TAIL);
  end

  // register writes and reads
  always_comb begin
    ctrl_d   = ctrl_q;
    rdData_d = 8'h00;
    if (regWrEn && regAddr == mcg_pkg::CTRL_OFFSET) begin
      ctrl_d = regWrData & mcg_pkg::CTRL_MASK;
    end
    if (regRdEn) begin
      case (regAddr)
        mcg_pkg::CTRL_OFFSET:   rdData_d = ctrl_q;
        mcg_pkg::STATUS_OFFSET: rdData_d = status;
        default:                rdData_d = 8'h00;
      endcase
    end
  end

  // state registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_q    <= mcg_pkg::CTRL_RESET;
      rdData_q  <= 8'h00;
      state_q   <= mcg_pkg::ST_RUN;
      tail_q    <= 10'h000;
      lfLevel_q <= 1'b0;
      pin_q     <= 1'b0;
      pinOe_q   <= 1'b0;
      xtalEn_q  <= 1'b1;
    end else begin
      ctrl_q    <= ctrl_d;
      rdData_q  <= rdData_d;
      state_q   <= state_d;
      tail_q    <= tail_d;
      lfLevel_q <= lfLevel_d;
      pin_q     <= pin_d;
      pinOe_q   <= 1'b1;
      xtalEn_q  <= xtalEn_d;
    end
  end

  // outputs straight from flops
  assign regRdData     = rdData_q;
  assign clockOutPinO  = pin_q;
  assign clockOutPinOe = pinOe_q;
  assign xtalEnable    = xtalEn_q;

endmodule : mcg_clock_output
`default_nettype wire

//--- mcg_clock_output_properties.sv
// port assertions for the clock output block
`timescale 1ns/10ps
`default_nettype none
module mcg_clock_output_properties (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  // ticks and mode
  input wire logic       xtalTick,
  input wire logic       lfTick,
  input wire logic       sleepCmd,
  input wire logic       irqPending,
  // outputs
  input wire logic       clockOutPinO,
  input wire logic       clockOutPinOe,
  input wire logic       xtalEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // pin driven once out of reset
  property p_oeOn; !$past(reset) |-> clockOutPinOe; endproperty
  a_oeOn: assert property (p_oeOn) else $error("pin enable low");
  // read data only in the cycle after a read
  property p_rdIdle; !$past(regRdEn) |-> regRdData == 8'h00; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
  property p_rdHigh;
    regRdEn && regAddr == mcg_pkg::CTRL_OFFSET |=> regRdData[7:6] == 2'h0;
  endproperty
  a_rdHigh: assert property (p_rdHigh) else $error("control top bits set");
  property p_rdMiss;
    regRdEn && regAddr != mcg_pkg::CTRL_OFFSET && regAddr != mcg_pkg::STATUS_OFFSET
      |=> regRdData == 8'h00;
  endproperty
  a_rdMiss: assert property (p_rdMiss) else $error("unmapped read not zero");
  // control readback right after a write
  property p_wrRd;
    logic [7:0] wd;
    (regWrEn && regAddr == mcg_pkg::CTRL_OFFSET, wd = regWrData & mcg_pkg::CTRL_MASK)
      ##1 (regRdEn && regAddr == mcg_pkg::CTRL_OFFSET) |=> regRdData == wd;
  endproperty
  a_wrRd: assert property (p_wrRd) else $error("control readback wrong");
  // pending interrupt keeps the crystal on
  property p_irqXtal; $past(irqPending) |-> xtalEnable; endproperty
  a_irqXtal: assert property (p_irqXtal) else $error("crystal off with irq");
  property p_xtalOff; !xtalEnable |-> $past(sleepCmd) && !$past(irqPending); endproperty
  a_xtalOff: assert property (p_xtalOff) else $error("crystal off while awake");
  property p_statRd;
    regRdEn && regAddr == mcg_pkg::STATUS_OFFSET |=> regRdData[7:3] == 5'h00;
  endproperty
  a_statRd: assert property (p_statRd) else $error("status top bits set");
endmodule : mcg_clock_output_properties
bind mcg_clock_output mcg_clock_output_properties chk_u (.mclk(mclk), .reset(reset),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .xtalTick(xtalTick), .lfTick(lfTick), .sleepCmd(sleepCmd),
  .irqPending(irqPending), .clockOutPinO(clockOutPinO), .clockOutPinOe(clockOutPinOe),
  .xtalEnable(xtalEnable));
`default_nettype wire

//--- mcg_host_model.sv
// host controller model that samples the output pin on mclk
`timescale 1ns/10ps
`default_nettype none
module mcg_host_model (
  // clock and pin
  input  wire logic mclk,
  input  wire logic pinO,
  input  wire logic pinOe,
  // measurements
  output var  int   rises,
  output var  int   period
);
  logic pinQ = 1'b0;
  int   since = 0;
  wire  pinW = pinOe ? pinO : 1'b0; // pulled low when undriven
  initial rises = 0;
  initial period = 0;
  // count rising edges and time between them
  always @(posedge mclk) begin
    pinQ  <= pinW;
    since <= since + 1;
    if (pinW && !pinQ) begin
      rises  <= rises + 1;
      period <= since + 1;
      since  <= 0;
    end
  end
endmodule : mcg_host_model
`default_nettype wire

//--- mcg_pkg.sv
// constants shared by the microcontroller clock output block
package mcg_pkg;

  // register map
  localparam logic [7:0] CTRL_OFFSET   = 8'h0a;
  localparam logic [7:0] STATUS_OFFSET = 8'h0b;
  localparam logic [7:0] CTRL_RESET    = 8'h0b;
  localparam logic [7:0] CTRL_MASK     = 8'h3f;

  // control field positions
  localparam int SEL_LSB   = 0;
  localparam int LFEN_BIT  = 3;
  localparam int TAIL_LSB  = 4;

  // status field positions
  localparam int STAT_RUN_BIT  = 0;
  localparam int STAT_LF_BIT   = 1;
  localparam int STAT_TAIL_BIT = 2;

  // divider select codes
  localparam logic [2:0] SEL_30MHZ = 3'h0;
  localparam logic [2:0] SEL_15MHZ = 3'h1;
  localparam logic [2:0] SEL_10MHZ = 3'h2;
  localparam logic [2:0] SEL_4MHZ  = 3'h3;
  localparam logic [2:0] SEL_3MHZ  = 3'h4;
  localparam logic [2:0] SEL_2MHZ  = 3'h5;
  localparam logic [2:0] SEL_1MHZ  = 3'h6;
  localparam logic [2:0] SEL_LF    = 3'h7;

  // output periods in crystal half-cycle ticks (30 MHz crystal, 60 M ticks/s)
  localparam logic [6:0] PER_30MHZ = 7'h02;
  localparam logic [6:0] PER_15MHZ = 7'h04;
  localparam logic [6:0] PER_10MHZ = 7'h06;
  localparam logic [6:0] PER_4MHZ  = 7'h0f;
  localparam logic [6:0] PER_3MHZ  = 7'h14;
  localparam logic [6:0] PER_2MHZ  = 7'h1e;
  localparam logic [6:0] PER_1MHZ  = 7'h3c;

  // tail lengths in output cycles
  localparam logic [9:0] TAIL_NONE = 10'h000;
  localparam logic [9:0] TAIL_128  = 10'h080;
  localparam logic [9:0] TAIL_256  = 10'h100;
  localparam logic [9:0] TAIL_512  = 10'h200;

  // output controller states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_TAIL,
    ST_STOPPED,
    ST_LOWF
  } mcg_state_t;

endpackage : mcg_pkg

//--- tb_mcu_clock_output_gen.sv
// self-checking bench for the clock output block
`timescale 1ns/10ps
`default_nettype none
module tb_mcu_clock_output_gen;
  logic       mclk = 0, reset = 1, regWrEn = 0, regRdEn = 0, xtalTick = 1;
  logic       lfTick = 0, sleepCmd = 0, irqPending = 0;
  logic       clockOutPinO, clockOutPinOe, xtalEnable;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, wd;
  int         err_count = 0, comparisons = 0, cyc = 0, seed = 19209;
  int         rises, period, n, m, k, tl;
  mcg_clock_output dut_u (.mclk(mclk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .xtalTick(xtalTick), .lfTick(lfTick), .sleepCmd(sleepCmd), .irqPending(irqPending),
    .clockOutPinO(clockOutPinO), .clockOutPinOe(clockOutPinOe), .xtalEnable(xtalEnable));
  mcg_host_model host_u (.mclk(mclk), .pinO(clockOutPinO), .pinOe(clockOutPinOe),
    .rises(rises), .period(period));
  task automatic stop_test();
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1;
    @(posedge mclk) regWrEn <= 0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRdEn <= 1;
    @(posedge mclk) regRdEn <= 0;
    #1 cmp(regRdData, exp);
    @(posedge mclk);
  endtask : rdc
  // period in clocks: one crystal half-cycle tick per clock, lf tick every fourth
  function automatic int expPer(input int s);
    int f[7] = '{30, 15, 10, 4, 3, 2, 1};
    return (s == 7) ? 8 : 60 / f[s];
  endfunction : expPer
  // status word expected: running, low-frequency source, tail active
  function automatic logic [7:0] expStat(input logic run, input logic lf, input logic tailOn);
    logic [7:0] s;
    s = 8'h00;
    s[mcg_pkg::STAT_RUN_BIT]  = run;
    s[mcg_pkg::STAT_LF_BIT]   = lf;
    s[mcg_pkg::STAT_TAIL_BIT] = tailOn;
    return s;
  endfunction : expStat
  // lf tick source and hang guard
  always @(posedge mclk) begin
    cyc    <= cyc + 1;
    lfTick <= (cyc % 4 == 3);
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  always #12.5 mclk = ~mclk;
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    rdc(mcg_pkg::CTRL_OFFSET, mcg_pkg::CTRL_RESET);
    rdc(mcg_pkg::STATUS_OFFSET, expStat(1, 0, 0));
    repeat (200) @(posedge mclk);
    cmp(period, expPer(3));
    // random control writes, status writes ignored, unmapped reads
    for (n = 0; n < 20; n++) begin
      wd = $random(seed);
      wr(mcg_pkg::CTRL_OFFSET, wd);
      rdc(mcg_pkg::CTRL_OFFSET, wd & mcg_pkg::CTRL_MASK);
      wr(mcg_pkg::STATUS_OFFSET, ~wd);
      rdc(mcg_pkg::CTRL_OFFSET, wd & mcg_pkg::CTRL_MASK);
      rdc({wd[7:4], 4'h0}, 8'h00);
    end
    // every divider code while awake
    for (n = 0; n < 8; n++) begin
      wr(mcg_pkg::CTRL_OFFSET, n[7:0]);
      repeat (300) @(posedge mclk);
      cmp(period, expPer(n));
    end
    // every tail length, then clean stop and wake
    for (n = 0; n < 4; n++) begin
      tl = (n == 0) ? 0 : 64 << n;
      wr(mcg_pkg::CTRL_OFFSET, {2'h0, n[1:0], 4'h0});
      repeat (20) @(posedge mclk);
      sleepCmd <= 1;
      // host counts a rise two edges late; skip rises from before the command
      repeat (2) @(posedge mclk);
      k = rises;
      rdc(mcg_pkg::STATUS_OFFSET, expStat(n != 0, 0, n != 0));
      for (m = 0; m < 1200 && xtalEnable !== 1'b0; m++) @(posedge mclk);
      cmp(rises - k >= tl && rises - k <= tl + 1, 1);
      k = rises;
      repeat (50) @(posedge mclk);
      cmp(rises - k, 0);
      cmp(clockOutPinO, 0);
      rdc(mcg_pkg::STATUS_OFFSET, expStat(0, 0, 0));
      sleepCmd <= 0;
      repeat (100) @(posedge mclk);
      cmp(period, 2);
    end
    // sleep with lf switch, first held off by a pending interrupt
    wd = $random(seed);
    wr(mcg_pkg::CTRL_OFFSET, {5'h01, wd[2:0]});
    irqPending <= 1;
    sleepCmd   <= 1;
    repeat (300) @(posedge mclk);
    cmp(xtalEnable, 1);
    cmp(period, expPer(wd[2:0]));
    rdc(mcg_pkg::STATUS_OFFSET, expStat(1, wd[2:0] == 3'h7, 0));
    irqPending <= 0;
    repeat (100) @(posedge mclk);
    cmp(xtalEnable, 0);
    cmp(period, 8);
    rdc(mcg_pkg::STATUS_OFFSET, expStat(1, 1, 0));
    sleepCmd <= 0;
    repeat (300) @(posedge mclk);
    cmp(period, expPer(wd[2:0]));
    stop_test();
  end
endmodule : tb_mcu_clock_output_gen
`default_nettype wire
